// ---- rtl/qdsl_host.sv ----
// Host end: turns user requests into serial frames and strobes.
`timescale 1ns/100ps
`include "qdsl_params.svh"
module qdsl_host (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Link to the device.
  qdsl_link_if.host link,
  // Request port.
  input wire logic cmd_valid_in,
  input qdsl_pkg::qdsl_op_t cmd_op_in,
  input wire logic [1:0] cmd_addr_in,
  input wire logic cmd_bcast_in,
  input qdsl_pkg::qdsl_code_t cmd_code_in,
  input wire logic cmd_clear_sel_in,
  // Request status.
  output logic cmd_ready_out,
  output logic busy_out
);

  qdsl_pkg::qdsl_hstate_t state_reg;
  qdsl_pkg::qdsl_op_t op_reg;
  logic [`QDSL_WORD_BITS-1:0] word_reg;
  logic [4:0] bit_cnt_reg;
  logic [`QDSL_CNT_W-1:0] cnt_reg;
  logic link_clk_reg;
  logic cs_n_reg;
  logic serial_in_reg;
  logic load_n_reg;
  logic update_reg;
  logic clear_reg;
  logic clear_sel_reg;
  logic ready_reg;
  logic busy_reg;
  logic take;
  logic cnt_done;

  assign take = cmd_valid_in & ready_reg;
  assign cnt_done = (cnt_reg == `QDSL_STROBE_CYC - 4'h1);

  // Link clock divider: half a period per core cycle. It stays high for
  // one extra cycle at frame end so chip select rises with the clock high.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      link_clk_reg <= 1'b1;
    end else if (state_reg != qdsl_pkg::QDSL_H_CS_END) begin
      link_clk_reg <= ~link_clk_reg;
    end
  end

  // Request acceptance and the sequencer.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= qdsl_pkg::QDSL_H_IDLE;
      op_reg <= qdsl_pkg::QDSL_OP_WRITE;
      word_reg <= '0;
      bit_cnt_reg <= 5'h00;
      cnt_reg <= '0;
      cs_n_reg <= 1'b1;
      serial_in_reg <= 1'b0;
      clear_sel_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        qdsl_pkg::QDSL_H_IDLE: begin
          cnt_reg <= '0;
          bit_cnt_reg <= 5'h00;
          if (take) begin
            op_reg <= cmd_op_in;
            word_reg <= {cmd_addr_in, cmd_bcast_in, 5'h00, cmd_code_in};
            if (cmd_op_in == qdsl_pkg::QDSL_OP_WRITE) begin
              state_reg <= qdsl_pkg::QDSL_H_SHIFT;
            end else if (cmd_op_in == qdsl_pkg::QDSL_OP_UPDATE) begin
              state_reg <= qdsl_pkg::QDSL_H_PULSE;
            end else begin
              clear_sel_reg <= cmd_clear_sel_in;
              state_reg <= qdsl_pkg::QDSL_H_SETUP;
            end
          end
        end
        qdsl_pkg::QDSL_H_SHIFT: begin
          if (link_clk_reg) begin
            // Falling link edge: present the next bit, select the device.
            cs_n_reg <= 1'b0;
            serial_in_reg <= word_reg[`QDSL_WORD_BITS-1];
            word_reg <= {word_reg[`QDSL_WORD_BITS-2:0], 1'b0};
          end else if (!cs_n_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `QDSL_LAST_BIT_IDX) begin
              state_reg <= qdsl_pkg::QDSL_H_CS_END;
            end
          end
        end
        qdsl_pkg::QDSL_H_CS_END: begin
          cs_n_reg <= 1'b1;
          state_reg <= qdsl_pkg::QDSL_H_PULSE;
        end
        qdsl_pkg::QDSL_H_SETUP, qdsl_pkg::QDSL_H_PULSE: begin
          cnt_reg <= cnt_done ? '0 : cnt_reg + 4'h1;
          if (cnt_done) begin
            state_reg <= (state_reg == qdsl_pkg::QDSL_H_SETUP) ?
                         qdsl_pkg::QDSL_H_PULSE : qdsl_pkg::QDSL_H_RECOVER;
          end
        end
        qdsl_pkg::QDSL_H_RECOVER: begin
          cnt_reg <= cnt_done ? '0 : cnt_reg + 4'h1;
          if (cnt_done) begin
            state_reg <= qdsl_pkg::QDSL_H_IDLE;
          end
        end
        default: begin
          state_reg <= qdsl_pkg::QDSL_H_IDLE;
        end
      endcase
    end
  end

  // Strobes follow the sequencer one cycle later; pulse lengths keep.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      load_n_reg <= 1'b1;
      update_reg <= 1'b0;
      clear_reg <= 1'b0;
    end else begin
      load_n_reg <= ~(state_reg == qdsl_pkg::QDSL_H_PULSE &&
                      op_reg == qdsl_pkg::QDSL_OP_WRITE);
      update_reg <= (state_reg == qdsl_pkg::QDSL_H_PULSE &&
                     op_reg == qdsl_pkg::QDSL_OP_UPDATE);
      clear_reg <= (state_reg == qdsl_pkg::QDSL_H_PULSE &&
                    op_reg == qdsl_pkg::QDSL_OP_CLEAR);
    end
  end

  // Ready and busy track whether the sequencer will take a request.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ready_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else if (take) begin
      ready_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else if (state_reg == qdsl_pkg::QDSL_H_RECOVER && cnt_done) begin
      ready_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
  end

  assign link.link_clk = link_clk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.serial_in = serial_in_reg;
  assign link.load_n = load_n_reg;
  assign link.output_reg_update = update_reg;
  assign link.clear = clear_reg;
  assign link.clear_value_select = clear_sel_reg;
  assign cmd_ready_out = ready_reg;
  assign busy_out = busy_reg;

endmodule // qdsl_host

// ---- rtl/qdsl_params.svh ----
// Constants shared by both ends of the quad converter serial load link.
`ifndef QDSL_PARAMS_SVH
`define QDSL_PARAMS_SVH

// Word layout, sent most significant bit first.
`define QDSL_WORD_BITS 24
`define QDSL_CODE_BITS 16
`define QDSL_NUM_CHAN 4
`define QDSL_ADDR_HI_BIT 23
`define QDSL_ADDR_LO_BIT 22
`define QDSL_BCAST_BIT 21
`define QDSL_CODE_MSB 15
`define QDSL_LAST_BIT_IDX 5'h17

// Codes loaded by a clear event and by reset.
`define QDSL_MID_CODE 16'h8000
`define QDSL_ZERO_CODE 16'h0000
`define QDSL_RESET_CODE 16'h8000

// Synchroniser lanes inside the device.
`define QDSL_SY_LOAD 0
`define QDSL_SY_UPD 1
`define QDSL_SY_CLR 2
`define QDSL_SY_SEL 3
`define QDSL_SY_RST_VAL 4'h1

// Host timing, in nanoseconds and in core clock cycles.
`define QDSL_CORE_CLK_NS 40
`define QDSL_CEIL_CYC(ns) (((ns) + `QDSL_CORE_CLK_NS - 1) / `QDSL_CORE_CLK_NS)
`define QDSL_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define QDSL_LOAD_LOW_NS 30
`define QDSL_UPD_LOW_NS 100
`define QDSL_UPD_HIGH_NS 150
`define QDSL_CLR_HIGH_NS 10
`define QDSL_SEL_HOLD_NS 100
// The device samples strobes on the link clock (two core cycles a period)
// through two flip-flops, so every strobe phase lasts four link periods.
`define QDSL_SYNC_MIN_CYC 8
`define QDSL_DOC_MAX_CYC `QDSL_MAX(`QDSL_MAX(`QDSL_CEIL_CYC(`QDSL_LOAD_LOW_NS), \
  `QDSL_CEIL_CYC(`QDSL_UPD_LOW_NS)), `QDSL_MAX(`QDSL_CEIL_CYC(`QDSL_UPD_HIGH_NS), \
  `QDSL_MAX(`QDSL_CEIL_CYC(`QDSL_CLR_HIGH_NS), `QDSL_CEIL_CYC(`QDSL_SEL_HOLD_NS))))
`define QDSL_STROBE_CYC 4'(`QDSL_MAX(`QDSL_DOC_MAX_CYC, `QDSL_SYNC_MIN_CYC))
`define QDSL_CNT_W 4

`endif

// ---- rtl/qdsl_pkg.sv ----
// Types shared by both ends of the quad converter serial load link.
package qdsl_pkg;

  // One converter code.
  typedef logic [15:0] qdsl_code_t;

  // Operations the host user can request.
  typedef enum logic [1:0] {
    QDSL_OP_WRITE,
    QDSL_OP_UPDATE,
    QDSL_OP_CLEAR
  } qdsl_op_t;

  // Host sequencer states.
  typedef enum logic [2:0] {
    QDSL_H_IDLE,
    QDSL_H_SHIFT,
    QDSL_H_CS_END,
    QDSL_H_SETUP,
    QDSL_H_PULSE,
    QDSL_H_RECOVER
  } qdsl_hstate_t;

endpackage

// ---- rtl/qdsl_link_if.sv ----
// Interface joining the host and the device over the serial load link.
`timescale 1ns/100ps
interface qdsl_link_if;
  // Serial link.
  logic link_clk;
  logic cs_n;
  logic serial_in;
  logic serial_out;
  // Register load strobes and clear controls.
  logic load_n;
  logic output_reg_update;
  logic clear;
  logic clear_value_select;

  // The host makes the link clock and every control.
  modport host (
    output link_clk,
    output cs_n,
    output serial_in,
    output load_n,
    output output_reg_update,
    output clear,
    output clear_value_select,
    input serial_out
  );

  // The device answers only with its shift register end.
  modport dev (
    input link_clk,
    input cs_n,
    input serial_in,
    input load_n,
    input output_reg_update,
    input clear,
    input clear_value_select,
    output serial_out
  );
endinterface // qdsl_link_if

// ---- rtl/qdsl_device.sv ----
// Device end: serial shift register and double-buffered channel codes.
`timescale 1ns/100ps
// Functional notes
// - Low write control loads input registers.
// - Output registers copy only on update rising edge.
// - Clear acts on its rising edge.
// - Select high: clear loads mid-scale code.
// - Select low: clear loads all-zeros code.
// - 24-bit word opens with 2-bit channel address.
// - Then broadcast bit, five ignored, code MSB-first.
// - Clear hits all four channels at once.
// - Link active only while chip select low.
// - Clear works independent of the shift clock (here it is sampled on the link clock).
// - Broadcast loads all inputs, else addressed one.
// - Input registers follow shifter while control low.
// - Shift on rising edge of select OR clock (here only on link clock rises with select low).
// - Serial output is the driven shifter end.
`include "qdsl_params.svh"
module qdsl_device (
  // Serial link and control strobes from the host.
  qdsl_link_if.dev link,
  // Reset, synchronous to the link clock.
  input wire logic rst_in,
  // Channel codes driving the converters.
  output qdsl_pkg::qdsl_code_t [`QDSL_NUM_CHAN-1:0] chan_code_out,
  // Channel input registers, waiting for the next update.
  output qdsl_pkg::qdsl_code_t [`QDSL_NUM_CHAN-1:0] chan_input_out,
  // Last frame did not carry exactly one word.
  output logic frame_error_out
);

  logic [`QDSL_WORD_BITS-1:0] shift_reg;
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic upd_prev_reg;
  logic clr_prev_reg;
  logic cs_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic frame_error_reg;
  qdsl_pkg::qdsl_code_t [`QDSL_NUM_CHAN-1:0] in_reg;
  qdsl_pkg::qdsl_code_t [`QDSL_NUM_CHAN-1:0] out_reg;
  logic load_active;
  logic update_edge;
  logic clear_edge;
  logic frame_end;
  logic bcast;
  logic [1:0] chan_addr;
  qdsl_pkg::qdsl_code_t shifted_code;
  qdsl_pkg::qdsl_code_t clear_code;

  // Serial shift register. The gated clock of select OR clock is built
  // as a clock-qualified shift: with select low every rising link edge
  // moves one bit in; with select high nothing moves.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      shift_reg <= '0;
    end else if (!link.cs_n) begin
      shift_reg <= {shift_reg[`QDSL_WORD_BITS-2:0], link.serial_in};
    end
  end

  // The far end of the shift register feeds the next device in a chain.
  assign link.serial_out = shift_reg[`QDSL_WORD_BITS-1];

  // Word fields, read straight from the shift register.
  assign chan_addr = {shift_reg[`QDSL_ADDR_HI_BIT],
                      shift_reg[`QDSL_ADDR_LO_BIT]};
  assign bcast = shift_reg[`QDSL_BCAST_BIT];
  assign shifted_code = shift_reg[`QDSL_CODE_MSB:0];

  // The strobes and the clear controls arrive with no fixed relation to
  // the link clock, so each passes two flip-flops before use. Only the
  // second stage is looked at.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      meta_reg <= `QDSL_SY_RST_VAL;
      sync_reg <= `QDSL_SY_RST_VAL;
    end else begin
      meta_reg <= {link.clear_value_select, link.clear,
                   link.output_reg_update, link.load_n};
      sync_reg <= meta_reg;
    end
  end

  // Previous samples for edge detection of update and clear.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      upd_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      upd_prev_reg <= sync_reg[`QDSL_SY_UPD];
      clr_prev_reg <= sync_reg[`QDSL_SY_CLR];
    end
  end

  // Level and edge decodes. The update and clear levels by themselves
  // do nothing; only the low-to-high step counts.
  assign load_active = ~sync_reg[`QDSL_SY_LOAD];
  assign update_edge = sync_reg[`QDSL_SY_UPD] & ~upd_prev_reg;
  assign clear_edge = sync_reg[`QDSL_SY_CLR] & ~clr_prev_reg;

  // The select is sampled together with the clear edge; the host holds
  // it steady around the clear pulse, so both lanes agree.
  assign clear_code = sync_reg[`QDSL_SY_SEL] ? `QDSL_MID_CODE
                                             : `QDSL_ZERO_CODE;

  // Input registers. While the write control stays low they follow the
  // shift register every link cycle, so shifting during a load rewrites
  // whichever channel the moving address bits point at. Clear wins over
  // a write in the same cycle so the known state is never half-reached.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        in_reg[i] <= `QDSL_RESET_CODE;
      end
    end else if (clear_edge) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        in_reg[i] <= clear_code;
      end
    end else if (load_active) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        if (bcast || chan_addr == 2'(i)) begin
          in_reg[i] <= shifted_code;
        end
      end
    end
  end

  // Output registers. They change only on a clear edge or an update
  // edge; a clear edge writes the input stage in the same cycle.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        out_reg[i] <= `QDSL_RESET_CODE;
      end
    end else if (clear_edge) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        out_reg[i] <= clear_code;
      end
    end else if (update_edge) begin
      for (int i = 0; i < `QDSL_NUM_CHAN; i++) begin
        out_reg[i] <= in_reg[i];
      end
    end
  end

  // Frame length check. A frame ends at the first link edge that sees
  // select high after it was low. A clock-low select rise gives no
  // extra bit, since that next link edge already sees select high.
  assign frame_end = link.cs_n & ~cs_prev_reg;

  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= link.cs_n;
    end
  end

  // Bits counted per frame, saturating so long frames stay flagged.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      bit_cnt_reg <= 5'h00;
    end else if (frame_end) begin
      bit_cnt_reg <= 5'h00;
    end else if (!link.cs_n && bit_cnt_reg != 5'h1f) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Error flag, refreshed at the end of every frame.
  always_ff @(posedge link.link_clk) begin
    if (rst_in) begin
      frame_error_reg <= 1'b0;
    end else if (frame_end) begin
      frame_error_reg <= (bit_cnt_reg != 5'(`QDSL_WORD_BITS));
    end
  end

  // The converters see only the output stage.
  assign chan_code_out = out_reg;
  assign chan_input_out = in_reg;
  assign frame_error_out = frame_error_reg;

endmodule // qdsl_device

// ---- verif/qdsl_link_sva.sv ----
// Checker for the serial load link between the host and the device.
`timescale 1ns/100ps
module qdsl_link_sva (
  // Clocks and resets.
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic dev_rst_in,
  // Link signals.
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic load_n,
  input wire logic output_reg_update,
  input wire logic clear,
  input wire logic clear_value_select,
  // Device channel codes.
  input qdsl_pkg::qdsl_code_t [3:0] chan_code_out
);
  logic [4:0] bit_cnt;
  logic [3:0] strobe_hist;

  // Counts link rises in a frame; it holds the total until the next rise.
  always_ff @(posedge link_clk) begin
    if (cs_n) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Recent strobe levels, so that a code change can be traced to a cause.
  always_ff @(posedge link_clk) begin
    strobe_hist <= {strobe_hist[2:0], output_reg_update | clear};
  end

  AST_CS_RISE_HIGH: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(cs_n) |-> link_clk) else $error("select rose with clock low");
  AST_DATA_STABLE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (!cs_n && $rose(link_clk)) |-> $stable(serial_in))
    else $error("data moved at a shift edge");
  AST_FRAME_BITS: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(cs_n) |-> bit_cnt == 5'h18) else $error("frame not 24 bits");
  AST_LOAD_IDLE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !load_n |-> cs_n) else $error("load low inside a frame");
  AST_CODE_CAUSE: assert property (
    @(posedge link_clk) disable iff (dev_rst_in)
    $changed(chan_code_out) |-> |strobe_hist)
    else $error("code changed without strobe");
  AST_CLEAR_MID: assert property (
    @(posedge core_clk_in) disable iff (rst_in || dev_rst_in)
    ($rose(clear) && clear_value_select) |->
    ##[1:16] chan_code_out == {4{16'h8000}}) else $error("clear mid");
  AST_CLEAR_ZERO: assert property (
    @(posedge core_clk_in) disable iff (rst_in || dev_rst_in)
    ($rose(clear) && !clear_value_select) |->
    ##[1:16] chan_code_out == {4{16'h0000}}) else $error("clear zero");
  AST_SEL_HOLD: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    clear |-> $stable(clear_value_select)) else $error("select moved");
endmodule // qdsl_link_sva

// ---- verif/tb_top.sv ----
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/100ps
module tb_top;
  // Clock, resets and request port.
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dev_rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  qdsl_pkg::qdsl_op_t cmd_op_in = qdsl_pkg::QDSL_OP_WRITE;
  logic [1:0] cmd_addr_in = 2'h0;
  logic cmd_bcast_in = 1'b0;
  qdsl_pkg::qdsl_code_t cmd_code_in = 16'h0000;
  logic cmd_clear_sel_in = 1'b0;
  logic cmd_ready_out;
  logic busy_out;
  logic frame_error_out;
  qdsl_pkg::qdsl_code_t [3:0] chan_code_out;
  qdsl_pkg::qdsl_code_t [3:0] chan_input_out;
  // Bench model of both register stages.
  qdsl_pkg::qdsl_code_t [3:0] exp_in;
  qdsl_pkg::qdsl_code_t [3:0] exp_out;
  logic [15:0] lfsr_reg = 16'h0032;
  int fail_count = 0;
  int checks = 0;

  qdsl_link_if link_if ();
  qdsl_host qdsl_host_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .link(link_if), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_bcast_in(cmd_bcast_in),
    .cmd_code_in(cmd_code_in), .cmd_clear_sel_in(cmd_clear_sel_in),
    .cmd_ready_out(cmd_ready_out), .busy_out(busy_out));
  qdsl_device qdsl_device_inst (.link(link_if), .rst_in(dev_rst_in),
    .chan_code_out(chan_code_out), .chan_input_out(chan_input_out),
    .frame_error_out(frame_error_out));
  qdsl_link_sva qdsl_link_sva_inst (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .dev_rst_in(dev_rst_in), .link_clk(link_if.link_clk),
    .cs_n(link_if.cs_n), .serial_in(link_if.serial_in),
    .load_n(link_if.load_n), .output_reg_update(link_if.output_reg_update),
    .clear(link_if.clear), .clear_value_select(link_if.clear_value_select),
    .chan_code_out(chan_code_out));

  // Core clock, 40 ns period.
  always #20 core_clk_in = ~core_clk_in;

  // Pseudo-random source; a fixed start keeps runs repeatable.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Code that a clear event loads for a given select level.
  function automatic logic [15:0] clr_code(input logic s);
    return s ? 16'h8000 : 16'h0000;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Runs one request to completion, then compares against the model.
  task automatic do_op(input qdsl_pkg::qdsl_op_t op, input logic [1:0] a,
      input logic b, input logic [15:0] c, input logic s);
    int n;
    int m;
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_op_in <= op;
    cmd_addr_in <= a;
    cmd_bcast_in <= b;
    cmd_code_in <= c;
    cmd_clear_sel_in <= s;
    for (n = 0; n < 20 && cmd_ready_out !== 1'b1; n++)
      @(posedge core_clk_in);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    // Ready must drop, then rise again, within bounded waits.
    for (m = 0; m < 8 && cmd_ready_out !== 1'b0; m++)
      @(posedge core_clk_in);
    if (n == 20 || m == 8) begin
      fail_count++;
      report_and_stop();
    end
    for (n = 0; n < 800 && cmd_ready_out !== 1'b1; n++)
      @(posedge core_clk_in);
    if (n == 800) begin
      fail_count++;
      report_and_stop();
    end
    case (op)
      qdsl_pkg::QDSL_OP_WRITE: begin
        for (n = 0; n < 4; n++)
          if (b || a == n[1:0]) exp_in[n] = c;
      end
      qdsl_pkg::QDSL_OP_UPDATE: begin
        exp_out = exp_in;
      end
      default: begin
        exp_in = {4{clr_code(s)}};
        exp_out = exp_in;
      end
    endcase
    // A finished sequence must leave the host idle again.
    check(64'(busy_out), 64'h0);
    check(chan_input_out, exp_in);
    check(chan_code_out, exp_out);
    if (op == qdsl_pkg::QDSL_OP_WRITE) begin
      check(64'(link_if.serial_out), 64'(a[1]));
      check(64'(frame_error_out), 64'h0);
    end
  endtask

  // Main sequence: corner cases first, then a random mix.
  initial begin
    int k;
    exp_in = {4{16'h8000}};
    exp_out = exp_in;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // The device reset runs on the link clock, so it is released later.
    repeat (10) @(posedge core_clk_in);
    dev_rst_in <= 1'b0;
    for (k = 0; k < 4; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      do_op(qdsl_pkg::QDSL_OP_WRITE, k[1:0], 1'b0, lfsr_reg, 1'b0);
    end
    do_op(qdsl_pkg::QDSL_OP_UPDATE, 2'h0, 1'b0, 16'h0000, 1'b0);
    do_op(qdsl_pkg::QDSL_OP_WRITE, 2'h2, 1'b1, 16'hffff, 1'b0);
    do_op(qdsl_pkg::QDSL_OP_UPDATE, 2'h0, 1'b0, 16'h0000, 1'b0);
    do_op(qdsl_pkg::QDSL_OP_CLEAR, 2'h0, 1'b0, 16'h0000, 1'b1);
    do_op(qdsl_pkg::QDSL_OP_WRITE, 2'h1, 1'b1, 16'h1234, 1'b0);
    do_op(qdsl_pkg::QDSL_OP_UPDATE, 2'h0, 1'b0, 16'h0000, 1'b0);
    do_op(qdsl_pkg::QDSL_OP_CLEAR, 2'h3, 1'b0, 16'h0000, 1'b0);
    for (k = 0; k < 24; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      do_op((lfsr_reg[1:0] == 2'h3) ? qdsl_pkg::QDSL_OP_WRITE :
        qdsl_pkg::qdsl_op_t'(lfsr_reg[1:0]), lfsr_reg[3:2], lfsr_reg[4],
        lfsr_next(lfsr_reg), lfsr_reg[5]);
    end
    report_and_stop();
  end
endmodule // tb_top
